// file: verilog/srsc_pkg.sv
// Shared constants for the standby release and subclock control pair.
// Assumes one 200 MHz clock and an active-low asynchronous reset at both ends.
package srsc_pkg;
  // ==========================================================
  // Device register select on the link
  typedef enum logic [1:0] {SRSC_R_GUARD, SRSC_R_LEVEL, SRSC_R_PCC, SRSC_R_OSC_SETTLE_SELECT} srsc_reg_t;
  // ==========================================================
  // Protection and regulator codes
  localparam logic [7:0] SRSC_GUARD_KEY = 8'hc9;
  localparam logic [7:0] SRSC_GUARD_LOCK = 8'h00;
  localparam logic [7:0] SRSC_LV_NORMAL = 8'h00;
  localparam logic [7:0] SRSC_LV_STOP = 8'h01;
  localparam logic [7:0] SRSC_LV_SUB = 8'h02;
  localparam logic [7:0] SRSC_GUARD_RST = 8'h00;
  localparam logic [7:0] SRSC_LEVEL_RST = 8'h00;
  // ==========================================================
  // Clock control fields
  localparam int SRSC_DIV_LSB = 0;
  localparam int SRSC_SUB_BIT = 3;
  localparam int SRSC_MCK_BIT = 6;
  localparam logic [7:0] SRSC_PCC_RST = 8'h03;
  localparam logic [2:0] SRSC_OSC_SETTLE_SELECT_RST = 3'h4;
  // Settle interval is 2^(SRSC_OST_BASE + select) cycles
  localparam int SRSC_OST_BASE = 4;
  localparam int SRSC_OST_W = 12;
  localparam int SRSC_SW_DLY = 4;
  // ==========================================================
  // Controller APB map
  localparam logic [3:0] SRSC_A_CTRL = 4'h0;
  localparam logic [3:0] SRSC_A_PRIO = 4'h4;
  localparam logic [3:0] SRSC_A_CMD = 4'h8;
  localparam logic [3:0] SRSC_A_STAT = 4'hc;
  localparam int SRSC_C_STOP = 0;
  localparam int SRSC_C_IE = 1;
  localparam int SRSC_C_NMA = 2;
  localparam int SRSC_C_NMB = 3;
  localparam int SRSC_C_INTM = 4;
  localparam int SRSC_C_ISR = 5;
  typedef enum logic [1:0] {SRSC_OP_LEVEL, SRSC_OP_SUB, SRSC_OP_OSC_SETTLE_SELECT, SRSC_OP_MCK} srsc_op_t;
  localparam int SRSC_PRIO_W = 3;
endpackage

// file: verilog/srsc_if.sv
// Link between the standby controller (CPU side) and the standby device.
// Assumes both ends share clock_in; no tristate signals are carried.
interface srsc_if;
  import srsc_pkg::*;
  // ==========================================================
  // Register writes and sources, controller to device
  logic reg_wr;
  srsc_reg_t reg_sel;
  logic [7:0] reg_wdata;
  logic stop_enter;
  logic [1:0] nmi_req;
  logic nmi_mask_a;
  logic nmi_mask_b;
  logic maskable_req;
  logic maskable_mask;
  logic reset_req;
  logic int_enable;
  logic in_isr;
  logic [SRSC_PRIO_W-1:0] req_prio;
  logic [SRSC_PRIO_W-1:0] serv_prio;
  logic [2:0] opt_settle;
  // ==========================================================
  // Device state back to the controller
  logic stopped;
  logic resume;
  logic take_handler;
  logic keep_pending;
  logic [7:0] level;
  logic [7:0] guard;
  logic [7:0] pcc;
  logic [2:0] osc_settle_select;
  logic clock_source_flag;
  logic main_osc_en;
  logic regulator_low;
  modport dev (input reg_wr, reg_sel, reg_wdata, stop_enter, nmi_req, nmi_mask_a, nmi_mask_b,
    maskable_req, maskable_mask, reset_req, int_enable, in_isr, req_prio, serv_prio, opt_settle,
    output stopped, resume, take_handler, keep_pending, level, guard, pcc, osc_settle_select,
    clock_source_flag, main_osc_en, regulator_low);
  modport ctl (output reg_wr, reg_sel, reg_wdata, stop_enter, nmi_req, nmi_mask_a, nmi_mask_b,
    maskable_req, maskable_mask, reset_req, int_enable, in_isr, req_prio, serv_prio, opt_settle,
    input stopped, resume, take_handler, keep_pending, level, guard, pcc, osc_settle_select,
    clock_source_flag, main_osc_en, regulator_low);
endinterface

// file: verilog/srsc_dev.sv
// Standby device end: STOP release, settle timing, regulator and clock source.
// Assumes the controller end drives the srsc_if dev modport on the same clock.
// Function
// - Wake on unmasked NMI, pin, peripheral, reset
// - Resume only after full settle interval
// - Any allowed request wakes, priority ignored
// - Lower priority in ISR wakes, stays pending
// - Higher priority in ISR wakes and acknowledged
// - Masked requests never release STOP
// - NMI wake branches to handler unless reset also wakes
// - Maskable wake branches only if enabled
// - Reset wake acts as ordinary reset
// - Regulator normal again after interrupt wake
// - Software settle select covers NMI and maskable wake recovery
// - Level and guard kept after interrupt wake
// - Level restore uses guarded disabled sequence
// - Reset wake clears level and guard
// - Settle counter per select, resume on overflow
// - Reset wake uses option byte interval
// - Subclock select switches clock, flag reports
// - Main oscillator stop leaves subclock only
// - Level 02 in subclock drops regulator
// - Subclock change keeps divider bits
// - Divider keeps clock above four subclocks
// - Low-voltage subclock entry guarded sequence
module srsc_dev
  import srsc_pkg::*;
#(
  parameter int OST_W = SRSC_OST_W
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Link
  srsc_if.dev lnk,
  // User side
  output logic regulator_low_out,
  output logic main_osc_en_out,
  output logic sub_clock_sel_out,
  output logic cpu_run_out
);
  typedef enum {SRSC_RUN, SRSC_STOP, SRSC_SETTLE} srsc_state_t;
  srsc_state_t state_q;
  logic [7:0] level_q;
  logic [7:0] guard_q;
  logic [7:0] pcc_q;
  logic [2:0] osc_settle_select_q;
  logic armed_q;
  logic by_reset_q;
  logic by_nmi_q;
  logic [OST_W-1:0] cnt_q;
  logic [OST_W-1:0] cnt_end_q;
  logic [2:0] sw_cnt_q;
  logic flag_q;
  logic resume_q;
  logic handler_q;
  logic pending_q;
  logic nmi_ok;
  logic int_ok;
  logic wake;
  logic done;
  logic higher;

  // ==========================================================
  // Release sources
  assign nmi_ok = (lnk.nmi_req[0] & ~lnk.nmi_mask_a) | (lnk.nmi_req[1] & ~lnk.nmi_mask_b);
  assign int_ok = lnk.maskable_req & ~lnk.maskable_mask;
  // Priority plays no part in waking
  assign wake = nmi_ok | int_ok | lnk.reset_req;
  assign done = (cnt_q == cnt_end_q);
  // Smaller number means higher priority
  assign higher = ~lnk.in_isr | (lnk.req_prio < lnk.serv_prio);

  // ==========================================================
  // Standby sequence
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= SRSC_RUN;
    end else begin
      unique case (state_q)
        SRSC_RUN: begin
          if (lnk.stop_enter) begin
            state_q <= SRSC_STOP;
          end
        end
        SRSC_STOP: begin
          if (wake) begin
            state_q <= SRSC_SETTLE;
          end
        end
        SRSC_SETTLE: begin
          if (done) begin
            state_q <= SRSC_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Wake cause and settle counter
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      by_reset_q <= 1'b0;
      by_nmi_q <= 1'b0;
      cnt_q <= '0;
      cnt_end_q <= '0;
    end else if (state_q == SRSC_STOP && wake) begin
      by_reset_q <= lnk.reset_req;
      by_nmi_q <= nmi_ok;
      cnt_q <= '0;
      if (lnk.reset_req) begin
        cnt_end_q <= OST_W'((1 << (SRSC_OST_BASE + int'(lnk.opt_settle))) - 1);
      end else begin
        cnt_end_q <= OST_W'((1 << (SRSC_OST_BASE + int'(osc_settle_select_q))) - 1);
      end
    end else if (state_q == SRSC_SETTLE && !done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Resume decision, one-cycle strobes at counter overflow
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resume_q <= 1'b0;
      handler_q <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      resume_q <= (state_q == SRSC_SETTLE) && done;
      handler_q <= 1'b0;
      pending_q <= 1'b0;
      if (state_q == SRSC_SETTLE && done && !by_reset_q) begin
        if (by_nmi_q) begin
          handler_q <= 1'b1;
        end else if (lnk.int_enable && higher) begin
          handler_q <= 1'b1;
        end else begin
          pending_q <= lnk.in_isr & ~higher;
        end
      end
    end
  end

  // ==========================================================
  // Guarded regulator registers
  // Reset wake reinitialises as an ordinary reset would
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_q <= SRSC_LEVEL_RST;
      guard_q <= SRSC_GUARD_RST;
      armed_q <= 1'b0;
    end else if (lnk.reset_req) begin
      level_q <= SRSC_LEVEL_RST;
      guard_q <= SRSC_GUARD_RST;
      armed_q <= 1'b0;
    end else if (lnk.reg_wr) begin
      // Any write other than the key disarms, so a stray write blocks the level
      armed_q <= (lnk.reg_sel == SRSC_R_GUARD) && (lnk.reg_wdata == SRSC_GUARD_KEY);
      if (lnk.reg_sel == SRSC_R_GUARD) begin
        guard_q <= lnk.reg_wdata;
      end
      if (lnk.reg_sel == SRSC_R_LEVEL && armed_q) begin
        if (lnk.reg_wdata != SRSC_LV_SUB || flag_q) begin
          level_q <= lnk.reg_wdata;
        end
      end
    end
  end

  // ==========================================================
  // Clock control and settle select
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pcc_q <= SRSC_PCC_RST;
      osc_settle_select_q <= SRSC_OSC_SETTLE_SELECT_RST;
    end else if (lnk.reset_req) begin
      pcc_q <= SRSC_PCC_RST;
      osc_settle_select_q <= SRSC_OSC_SETTLE_SELECT_RST;
    end else if (lnk.reg_wr && lnk.reg_sel == SRSC_R_PCC) begin
      pcc_q <= lnk.reg_wdata;
      // Main oscillator cannot stop while it still clocks the system
      pcc_q[SRSC_MCK_BIT] <= lnk.reg_wdata[SRSC_MCK_BIT] & flag_q;
    end else if (lnk.reg_wr && lnk.reg_sel == SRSC_R_OSC_SETTLE_SELECT) begin
      osc_settle_select_q <= lnk.reg_wdata[2:0];
    end
  end

  // Flag follows the select after a short switch delay
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sw_cnt_q <= '0;
      flag_q <= 1'b0;
    end else if (pcc_q[SRSC_SUB_BIT] == flag_q) begin
      sw_cnt_q <= '0;
    end else if (sw_cnt_q == 3'(SRSC_SW_DLY - 1)) begin
      flag_q <= pcc_q[SRSC_SUB_BIT];
      sw_cnt_q <= '0;
    end else begin
      sw_cnt_q <= sw_cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  // Low voltage in STOP only while stopped; it recovers on wake by itself
  assign regulator_low_out = ((state_q == SRSC_STOP) && level_q == SRSC_LV_STOP) ||
                             (level_q == SRSC_LV_SUB);
  assign main_osc_en_out = (state_q == SRSC_RUN) && !pcc_q[SRSC_MCK_BIT];
  assign sub_clock_sel_out = flag_q;
  assign cpu_run_out = (state_q == SRSC_RUN);
  assign lnk.stopped = (state_q != SRSC_RUN);
  assign lnk.resume = resume_q;
  assign lnk.take_handler = handler_q;
  assign lnk.keep_pending = pending_q;
  assign lnk.level = level_q;
  assign lnk.guard = guard_q;
  assign lnk.pcc = pcc_q;
  assign lnk.osc_settle_select = osc_settle_select_q;
  assign lnk.clock_source_flag = flag_q;
  assign lnk.main_osc_en = main_osc_en_out;
  assign lnk.regulator_low = regulator_low_out;
endmodule

// file: verilog/srsc_ctl.sv
// Controller end: APB registers, guarded write sequences, source forwarding.
// Assumes an APB master on clock_in and the device on the srsc_if ctl modport.
module srsc_ctl
  import srsc_pkg::*;
#(
  parameter logic [2:0] DIV_MAX_SUB = 3'h5,
  parameter logic [2:0] OSC_SETTLE_SELECT_MIN = 3'h2
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [3:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Request sources
  input wire logic [1:0] nmi_in,
  input wire logic maskable_in,
  input wire logic reset_src_in,
  input wire logic [2:0] opt_settle_in,
  // Link
  srsc_if.ctl lnk
);
  typedef enum {SRSC_IDLE, SRSC_KEY, SRSC_LVL, SRSC_LOCK} srsc_seq_t;
  srsc_seq_t seq_q;
  logic [5:0] ctrl_q;
  logic [7:0] prio_q;
  logic [7:0] lvl_q;
  logic err_q;
  logic stop_q;
  logic acc;
  logic wr;
  logic cmd_wr;
  logic busy;
  srsc_op_t op;

  assign acc = psel_in && penable_in;
  assign busy = (seq_q != SRSC_IDLE);
  // Command writes stall while a guarded sequence is still running
  assign pready_out = !(pwrite_in && paddr_in == SRSC_A_CMD && busy);
  assign wr = acc && pwrite_in && pready_out;
  assign cmd_wr = wr && paddr_in == SRSC_A_CMD;
  assign op = srsc_op_t'(pwdata_in[9:8]);
  assign pslverr_out = 1'b0;

  // ==========================================================
  // Control and priority registers
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= '0;
      prio_q <= '0;
      stop_q <= 1'b0;
    end else begin
      stop_q <= wr && paddr_in == SRSC_A_CTRL && pwdata_in[SRSC_C_STOP];
      if (wr && paddr_in == SRSC_A_CTRL) begin
        ctrl_q <= pwdata_in[5:0];
      end
      if (wr && paddr_in == SRSC_A_PRIO) begin
        prio_q <= pwdata_in[7:0];
      end
    end
  end

  // ==========================================================
  // Command engine
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_q <= SRSC_IDLE;
      lvl_q <= SRSC_LV_NORMAL;
      err_q <= 1'b0;
    end else begin
      unique case (seq_q)
        SRSC_IDLE: begin
          if (cmd_wr) begin
            err_q <= 1'b0;
            if (op == SRSC_OP_LEVEL) begin
              // Guarded change only with maskable interrupts disabled
              if (!ctrl_q[SRSC_C_IE]) begin
                lvl_q <= pwdata_in[7:0];
                seq_q <= SRSC_KEY;
              end else begin
                err_q <= 1'b1;
              end
            end else if (op == SRSC_OP_SUB && pwdata_in[0] &&
                         lnk.pcc[SRSC_DIV_LSB +: 3] > DIV_MAX_SUB) begin
              err_q <= 1'b1;
            end
          end
        end
        SRSC_KEY: seq_q <= SRSC_LVL;
        SRSC_LVL: seq_q <= SRSC_LOCK;
        SRSC_LOCK: seq_q <= SRSC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Link write port, registered
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lnk.reg_wr <= 1'b0;
      lnk.reg_sel <= SRSC_R_GUARD;
      lnk.reg_wdata <= '0;
    end else begin
      lnk.reg_wr <= 1'b0;
      if (seq_q == SRSC_KEY) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_GUARD;
        lnk.reg_wdata <= SRSC_GUARD_KEY;
      end else if (seq_q == SRSC_LVL) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_LEVEL;
        lnk.reg_wdata <= lvl_q;
      end else if (seq_q == SRSC_LOCK) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_GUARD;
        lnk.reg_wdata <= SRSC_GUARD_LOCK;
      end else if (cmd_wr && op == SRSC_OP_SUB &&
                   !(pwdata_in[0] && lnk.pcc[SRSC_DIV_LSB +: 3] > DIV_MAX_SUB)) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_PCC;
        lnk.reg_wdata <= lnk.pcc;
        lnk.reg_wdata[SRSC_SUB_BIT] <= pwdata_in[0];
      end else if (cmd_wr && op == SRSC_OP_MCK) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_PCC;
        lnk.reg_wdata <= lnk.pcc;
        lnk.reg_wdata[SRSC_MCK_BIT] <= pwdata_in[0];
      end else if (cmd_wr && op == SRSC_OP_OSC_SETTLE_SELECT) begin
        lnk.reg_wr <= 1'b1;
        lnk.reg_sel <= SRSC_R_OSC_SETTLE_SELECT;
        // Too short a select would cut regulator and oscillator recovery
        lnk.reg_wdata <= {5'h00, (pwdata_in[2:0] < OSC_SETTLE_SELECT_MIN) ? OSC_SETTLE_SELECT_MIN : pwdata_in[2:0]};
      end
    end
  end

  // ==========================================================
  // Forwarding and read back
  assign lnk.stop_enter = stop_q;
  assign lnk.nmi_req = nmi_in;
  assign lnk.nmi_mask_a = ctrl_q[SRSC_C_NMA];
  assign lnk.nmi_mask_b = ctrl_q[SRSC_C_NMB];
  assign lnk.maskable_req = maskable_in;
  assign lnk.maskable_mask = ctrl_q[SRSC_C_INTM];
  assign lnk.reset_req = reset_src_in;
  assign lnk.int_enable = ctrl_q[SRSC_C_IE];
  assign lnk.in_isr = ctrl_q[SRSC_C_ISR];
  assign lnk.req_prio = prio_q[SRSC_PRIO_W-1:0];
  assign lnk.serv_prio = prio_q[4 +: SRSC_PRIO_W];
  assign lnk.opt_settle = opt_settle_in;

  always_comb begin
    prdata_out = '0;
    unique case (paddr_in)
      SRSC_A_CTRL: prdata_out = {26'h0, ctrl_q};
      SRSC_A_PRIO: prdata_out = {24'h0, prio_q};
      SRSC_A_CMD: prdata_out = {8'h00, lnk.pcc, lnk.guard, lnk.level};
      SRSC_A_STAT: prdata_out = {21'h0, lnk.osc_settle_select, busy, err_q, lnk.regulator_low,
                                 lnk.main_osc_en, lnk.clock_source_flag, lnk.keep_pending,
                                 lnk.take_handler, lnk.stopped};
      default: prdata_out = '0;
    endcase
  end
endmodule

// file: tb/srsc_monitor.sv
// Link checker for the standby controller and device pair.
// Assumes it sits beside the srsc_if instance on the shared clock.
module srsc_monitor
  import srsc_pkg::*;
(
  // Clock and reset
  input logic clock_in,
  input logic nrst_in,
  // Controller to device
  input logic reg_wr,
  input srsc_reg_t reg_sel,
  input logic [7:0] reg_wdata,
  input logic [1:0] nmi_req,
  input logic nmi_mask_a,
  input logic nmi_mask_b,
  input logic maskable_req,
  input logic maskable_mask,
  input logic reset_req,
  input logic int_enable,
  input logic in_isr,
  input logic [SRSC_PRIO_W-1:0] req_prio,
  input logic [SRSC_PRIO_W-1:0] serv_prio,
  // Device to controller
  input logic stopped,
  input logic resume,
  input logic take_handler,
  input logic keep_pending,
  input logic [7:0] level,
  input logic [7:0] guard,
  input logic [7:0] pcc,
  input logic clock_source_flag,
  input logic main_osc_en,
  input logic regulator_low
);
  // ======
  // Helpers
  logic nmi_on;
  logic int_on;
  logic wake;
  logic lvl_wr;
  logic key_q;
  logic [7:0] st_q;
  logic woke_q;
  logic nmi_wk_q;
  logic rst_wk_q;
  assign nmi_on = (nmi_req[0] & ~nmi_mask_a) | (nmi_req[1] & ~nmi_mask_b);
  assign int_on = maskable_req & ~maskable_mask;
  assign wake = nmi_on | int_on | reset_req;
  assign lvl_wr = reg_wr & (reg_sel == SRSC_R_LEVEL) & key_q;
  // Saturates so a long STOP never wraps below the settle minimum
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) st_q <= 8'h00;
    else if (!stopped) st_q <= 8'h00;
    else if (st_q != 8'hff) st_q <= st_q + 8'h01;
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) key_q <= 1'h0;
    else if (reset_req) key_q <= 1'h0;
    else if (reg_wr) key_q <= (reg_sel == SRSC_R_GUARD) && (reg_wdata == SRSC_GUARD_KEY);
  end
  // Wake cause is held from the first wake, since sources may drop before resume
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      woke_q <= 1'h0;
      nmi_wk_q <= 1'h0;
      rst_wk_q <= 1'h0;
    end else if (!stopped) begin
      woke_q <= 1'h0;
    end else if (wake && !woke_q) begin
      woke_q <= 1'h1;
      nmi_wk_q <= nmi_on;
      rst_wk_q <= reset_req;
    end
  end
  // ======
  // Properties
  default clocking mon_cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  a_masked_stays: assert property ($rose(stopped) && !wake ##1 !wake [*7] |=> stopped)
    else $error("stop left without an unmasked source");
  a_resume_exit: assert property ($fell(stopped) |-> ##[0:1] resume)
    else $error("stop left without resume pulse");
  a_settle_min: assert property ($fell(stopped) |-> st_q >= 8'h10)
    else $error("settle interval cut short");
  a_nmi_branch: assert property (resume && nmi_wk_q && !rst_wk_q |-> take_handler)
    else $error("nmi wake did not branch");
  a_di_no_branch: assert property (resume && !int_enable && !nmi_wk_q |-> !take_handler)
    else $error("branch taken with interrupts disabled");
  a_low_prio_pend: assert property (resume && int_on && !nmi_wk_q && !rst_wk_q && int_enable
    && in_isr && req_prio >= serv_prio |-> keep_pending && !take_handler)
    else $error("lower priority request acknowledged");
  a_high_prio_ack: assert property (resume && int_on && !nmi_wk_q && !rst_wk_q && int_enable
    && in_isr && req_prio < serv_prio |-> take_handler && !keep_pending)
    else $error("higher priority request not acknowledged");
  a_level_keyed: assert property ($changed(level) |-> $past(lvl_wr) || $past(lvl_wr, 2)
    || $past(reset_req) || $past(reset_req, 2))
    else $error("level changed without guard key");
  a_reset_clear: assert property (reset_req |=> level == SRSC_LEVEL_RST
    && guard == SRSC_GUARD_RST)
    else $error("reset left level or guard set");
  a_stop_reg_norm: assert property (!stopped && level == SRSC_LV_STOP |-> !regulator_low)
    else $error("regulator low while running");
  a_sub_low: assert property (!stopped && level == SRSC_LV_SUB |-> regulator_low)
    else $error("regulator not low in low voltage subclock");
  a_flag_follow: assert property ($rose(pcc[SRSC_SUB_BIT]) |-> ##[1:8] clock_source_flag)
    else $error("clock source flag did not follow");
  a_mck_halt: assert property (pcc[SRSC_MCK_BIT] |-> !main_osc_en)
    else $error("main oscillator runs while stopped by control");
endmodule

// file: tb/stop_release_subclock_ctrl_tb_top.sv
// Bench top: APB drives the controller, which faces the device over srsc_if.
// Assumes design files and srsc_monitor are compiled before it.
module stop_release_subclock_ctrl_tb_top
  import srsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Signals
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] nmi = 2'h0;
  logic mreq = 1'h0;
  logic rsrc = 1'h0;
  logic [2:0] opt = 3'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [31:0] r;
  logic reg_low;
  logic osc_en;
  logic sub_sel;
  logic cpu_run;
  int failures = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  // ======
  // Design and checker
  srsc_if lnk ();
  srsc_ctl u_srsc_ctl (.clock_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .pslverr_out(pslverr), .prdata_out(prdata), .nmi_in(nmi), .maskable_in(mreq),
    .reset_src_in(rsrc), .opt_settle_in(opt), .lnk(lnk));
  srsc_dev u_srsc_dev (.clock_in(clk), .nrst_in(nrst), .lnk(lnk), .regulator_low_out(reg_low),
    .main_osc_en_out(osc_en), .sub_clock_sel_out(sub_sel), .cpu_run_out(cpu_run));
  srsc_monitor u_srsc_monitor (.clock_in(clk), .nrst_in(nrst), .reg_wr(lnk.reg_wr),
    .reg_sel(lnk.reg_sel), .reg_wdata(lnk.reg_wdata), .nmi_req(lnk.nmi_req),
    .nmi_mask_a(lnk.nmi_mask_a), .nmi_mask_b(lnk.nmi_mask_b), .maskable_req(lnk.maskable_req),
    .maskable_mask(lnk.maskable_mask), .reset_req(lnk.reset_req), .int_enable(lnk.int_enable),
    .in_isr(lnk.in_isr), .req_prio(lnk.req_prio), .serv_prio(lnk.serv_prio),
    .stopped(lnk.stopped), .resume(lnk.resume), .take_handler(lnk.take_handler),
    .keep_pending(lnk.keep_pending), .level(lnk.level), .guard(lnk.guard), .pcc(lnk.pcc),
    .clock_source_flag(lnk.clock_source_flag), .main_osc_en(lnk.main_osc_en),
    .regulator_low(lnk.regulator_low));
  // ======
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Ready and read data are taken at the rising edge at which the slave takes the transfer
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] d);
    apb(1'h1, SRSC_A_CMD, {22'h0, op, d});
    for (int k = 0; k < 8; k++) begin
      apb(1'h0, SRSC_A_STAT, 32'h0);
      if (r[7] === 1'h0) break;
    end
  endtask
  task automatic wres(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lnk.resume !== 1'h1 && n < 3000);
    if (n >= 3000) failures++;
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ======
  // Scenarios
  task automatic t_rst;
    apb(1'h0, SRSC_A_STAT, 32'h0);
    chk(r[10:8], SRSC_OSC_SETTLE_SELECT_RST);
    chk(r[5:3], 3'h2);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[23:0], {SRSC_PCC_RST, SRSC_GUARD_RST, SRSC_LEVEL_RST});
    apb(1'h0, 4'h2, 32'h0);
    chk(r, 32'h0);
    $display("t_rst done");
  endtask
  task automatic t_nmi;
    int n;
    int e;
    // Select 0 is clamped up to 2, so the settle interval is 2^(base + 2)
    e = 2 ** (SRSC_OST_BASE + 2);
    // Back to back, so the select command stalls until the guarded sequence ends
    apb(1'h1, SRSC_A_CMD, {22'h0, SRSC_OP_LEVEL, SRSC_LV_STOP});
    cmd(SRSC_OP_OSC_SETTLE_SELECT, 8'h00);
    chk(r[10:8], 3'h2);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[15:0], {SRSC_GUARD_LOCK, SRSC_LV_STOP});
    apb(1'h1, SRSC_A_CTRL, 32'h5);
    @(posedge clk);
    nmi <= 2'h1;
    apb(1'h0, SRSC_A_STAT, 32'h0);
    apb(1'h0, SRSC_A_STAT, 32'h0);
    apb(1'h0, SRSC_A_STAT, 32'h0);
    chk(r[0], 1'h1);
    chk(r[5], 1'h1);
    @(posedge clk);
    nmi <= 2'h3;
    wres(n);
    chk(lnk.take_handler, 1'h1);
    chk(n >= e && n <= e + 8, 1'h1);
    chk(cpu_run, 1'h1);
    @(posedge clk);
    nmi <= 2'h0;
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[15:0], {SRSC_GUARD_LOCK, SRSC_LV_STOP});
    chk(reg_low, 1'h0);
    $display("t_nmi done");
  endtask
  task automatic t_dis;
    int n;
    apb(1'h1, SRSC_A_PRIO, 32'h7);
    apb(1'h1, SRSC_A_CTRL, 32'h21);
    @(posedge clk);
    mreq <= 1'h1;
    wres(n);
    chk(cpu_run, 1'h1);
    chk(lnk.take_handler, 1'h0);
    @(posedge clk);
    mreq <= 1'h0;
    $display("t_dis done");
  endtask
  task automatic t_isr;
    int n;
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, SRSC_A_PRIO, (i == 1) ? 32'h21 : 32'h23);
      apb(1'h1, SRSC_A_CTRL, 32'h23);
      @(posedge clk);
      mreq <= 1'h1;
      wres(n);
      chk(lnk.take_handler, i[0]);
      chk(lnk.keep_pending, !i[0]);
      @(posedge clk);
      mreq <= 1'h0;
    end
    $display("t_isr done");
  endtask
  task automatic t_rwk;
    int n;
    int e;
    e = 2 ** (SRSC_OST_BASE + 1);
    opt <= 3'h1;
    apb(1'h1, SRSC_A_CTRL, 32'h1);
    @(posedge clk);
    rsrc <= 1'h1;
    wres(n);
    chk(lnk.take_handler, 1'h0);
    chk(n >= e && n <= e + 8, 1'h1);
    @(posedge clk);
    rsrc <= 1'h0;
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[23:0], {SRSC_PCC_RST, SRSC_GUARD_RST, SRSC_LEVEL_RST});
    $display("t_rwk done");
  endtask
  task automatic t_sub;
    apb(1'h1, SRSC_A_CTRL, 32'h2);
    cmd(SRSC_OP_LEVEL, SRSC_LV_STOP);
    chk(r[6], 1'h1);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[7:0], SRSC_LEVEL_RST);
    apb(1'h1, SRSC_A_CTRL, 32'h0);
    cmd(SRSC_OP_LEVEL, SRSC_LV_SUB);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[7:0], SRSC_LV_NORMAL);
    cmd(SRSC_OP_SUB, 8'h0b);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[23:16], SRSC_PCC_RST | 8'(1 << SRSC_SUB_BIT));
    apb(1'h0, SRSC_A_STAT, 32'h0);
    chk(r[3], 1'h1);
    chk(sub_sel, 1'h1);
    cmd(SRSC_OP_MCK, 8'h4b);
    chk(osc_en, 1'h0);
    cmd(SRSC_OP_LEVEL, SRSC_LV_SUB);
    chk(reg_low, 1'h1);
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[7:0], SRSC_LV_SUB);
    @(posedge clk);
    rsrc <= 1'h1;
    @(posedge clk);
    rsrc <= 1'h0;
    apb(1'h0, SRSC_A_CMD, 32'h0);
    chk(r[15:0], {SRSC_GUARD_RST, SRSC_LEVEL_RST});
    $display("t_sub done");
  endtask
  // ======
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    t_rst;
    t_nmi;
    t_dis;
    t_isr;
    t_rwk;
    t_sub;
    final_report;
  end
  // About 20000 cycles, far above the expected run of a few hundred cycles
  initial begin
    #100000;
    failures++;
    final_report;
  end
endmodule
